// ===== ssg_defines.svh
// Register offsets, field positions, reset values and widths of the secure output gate.
`ifndef SSG_DEFINES_SVH
`define SSG_DEFINES_SVH

`define SSG_OFF_CTRL 12'h000
`define SSG_OFF_MODE 12'h004
`define SSG_OFF_FUNCMAP 12'h008
`define SSG_OFF_PHYSCLS 12'h00C
`define SSG_OFF_ARM_A 12'h010
`define SSG_OFF_ARM_B 12'h014
`define SSG_OFF_STATUS 12'h018
`define SSG_OFF_FAILED 12'h01C
`define SSG_OFF_INT_STAT 12'h020
`define SSG_OFF_INT_MASK 12'h024

`define SSG_CTRL_KEYGEN 0
`define SSG_CTRL_MANUAL 1
`define SSG_CTRL_SWLOAD 2
`define SSG_CTRL_RETEST 3
`define SSG_CTRL_ZEROIZE 4

`define SSG_ST_OPER 0
`define SSG_ST_DEGR 1
`define SSG_ST_ERR 2
`define SSG_ST_TEST 3
`define SSG_ST_ZERO 4
`define SSG_ST_SWOK 5
`define SSG_ST_APPR 6
`define SSG_ST_MODE 8

`define SSG_INT_PASS 0
`define SSG_INT_FAIL 1
`define SSG_INT_FAULT 2
`define SSG_INT_MODE 3
`define SSG_INT_W 4

`define SSG_MODE_W 2
`define SSG_NMODE 4
`define SSG_FUNCMAP_RST 32'hFFFFFFFF
`define SSG_PHYSCLS_RST 4'h0

`endif

// ===== ssg_pkg.sv
// Types shared by the secure output gate modules.
package ssg_pkg;

  // Controller states, one-hot.
  typedef enum logic [5:0] {
    SSG_START = 6'h01,
    SSG_WAIT = 6'h02,
    SSG_OPER = 6'h04,
    SSG_DEGR = 6'h08,
    SSG_ERR = 6'h10,
    SSG_ZERO = 6'h20
  } ssg_state_type;

endpackage : ssg_pkg

// ===== ssg_gate_if.sv
// Gate controls passed from the security controller to the output gate.
`timescale 1ns/10ps
interface ssg_gate_if;
  logic data_block;
  logic secret_open;
  modport ctrl (output data_block, output secret_open);
  modport gate (input data_block, input secret_open);
endinterface : ssg_gate_if

// ===== ssg_output_gate.sv
// Registered output gate for the data channels and the secret port.
`timescale 1ns/10ps
module ssg_output_gate #(
  parameter int NCH = 2,
  parameter int DW = 32
) (
  input wire logic mclk_i, // System clock.
  input wire logic rst_n_i, // Synchronised reset, active low.
  ssg_gate_if.gate gate, // Gate controls.
  input wire logic [NCH-1:0] ch_valid_i, // Channel data valid.
  input wire logic [NCH*DW-1:0] ch_data_i, // Channel data.
  output logic [NCH-1:0] ch_valid_o, // Gated channel valid.
  output logic [NCH*DW-1:0] ch_data_o, // Gated channel data.
  input wire logic secret_valid_i, // Secret word valid.
  input wire logic [DW-1:0] secret_data_i, // Secret word.
  output logic secret_valid_o, // Gated secret valid.
  output logic [DW-1:0] secret_data_o // Gated secret word.
);

  // ----------------------------------------------------------------
  // Channel gates
  // ----------------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < NCH; c++)
    begin : g_ch
      // A blocked channel forwards neither valid nor data.
      always_ff @(posedge mclk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          ch_valid_o[c] <= 1'b0;
          ch_data_o[c*DW +: DW] <= '0;
        end
        else
        begin
          ch_valid_o[c] <= ch_valid_i[c] & ~gate.data_block;
          ch_data_o[c*DW +: DW] <= gate.data_block ? '0 : ch_data_i[c*DW +: DW];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Secret port gate
  // ----------------------------------------------------------------
  // The secret leaves only on its own port and only while the gate is open.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      secret_valid_o <= 1'b0;
      secret_data_o <= '0;
    end
    else
    begin
      secret_valid_o <= secret_valid_i & gate.secret_open;
      secret_data_o <= gate.secret_open ? secret_data_i : '0;
    end
  end

endmodule : ssg_output_gate

// ===== ssg_secure_gate.sv
// Security state controller with APB registers and output gating.
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`include "ssg_defines.svh"
module ssg_secure_gate #(
  parameter int NCH = 2,
  parameter int DW = 32,
  parameter int NF = 8
) (
  input wire logic mclk_i, // System clock, 200 MHz.
  input wire logic reset_n_i, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB write.
  input wire logic [11:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped address.
  input wire logic sec_fault_i, // Security condition lost, pin.
  output logic selftest_req_o, // Self-test start pulse.
  output logic [NF-1:0] selftest_funcs_o, // Functions to test.
  input wire logic selftest_done_i, // Self-test finished pulse.
  input wire logic selftest_integ_fail_i, // Software integrity failed.
  input wire logic [NF-1:0] selftest_fail_i, // Failed functions.
  output logic zeroize_req_o, // Erase secrets request, level.
  input wire logic zeroize_done_i, // Erasure finished pulse.
  output logic [NF-1:0] func_enable_o, // Functions allowed to run.
  output logic approved_mode_o, // Approved mode indicator.
  output logic degraded_o, // Degraded indicator.
  output logic error_o, // Error indicator.
  output logic irq_o, // Interrupt, level.
  input wire logic [NCH-1:0] ch_valid_i, // Channel data valid.
  input wire logic [NCH*DW-1:0] ch_data_i, // Channel data.
  output logic [NCH-1:0] ch_valid_o, // Gated channel valid.
  output logic [NCH*DW-1:0] ch_data_o, // Gated channel data.
  input wire logic critical_secret_valid_i, // Secret word valid.
  input wire logic [DW-1:0] critical_secret_i, // Secret word.
  output logic critical_secret_valid_o, // Gated secret valid.
  output logic [DW-1:0] critical_secret_o // Gated secret word.
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  generate
    if (NF < 1 || NF > 8 || NCH < 1 || DW < 1)
    begin : g_bad_param
      $error("ssg_secure_gate: NF must be 1..8, NCH and DW at least 1");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Reset release and pin synchroniser
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_n;
  logic fault_meta;
  logic fault_sync;

  // Reset leaves through two flip-flops.
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Fault pin passes two flip-flops.
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fault_meta <= 1'b0;
      fault_sync <= 1'b0;
    end
    else
    begin
      fault_meta <= sec_fault_i;
      fault_sync <= fault_meta;
    end
  end

  // ----------------------------------------------------------------
  // Register bus decode
  // ----------------------------------------------------------------
  logic [4:0] ctrl;
  logic [`SSG_MODE_W-1:0] mode_sel;
  logic [31:0] funcmap;
  logic [`SSG_NMODE-1:0] physcls;
  logic arm_a;
  logic arm_b;
  logic [`SSG_INT_W-1:0] int_stat;
  logic [`SSG_INT_W-1:0] int_mask;
  logic [NF-1:0] failed;
  logic sw_ok;
  ssg_pkg::ssg_state_type state;
  logic wr;
  logic mode_chg;
  logic phys_chg;
  logic retest;
  logic zero_req;
  logic zero_to_err;
  logic [NF-1:0] mode_funcs;
  logic [`SSG_INT_W-1:0] ev;
  logic mapped;

  // Functions that a mode uses, taken from the function map.
  function automatic logic [NF-1:0] funcs_of(input logic [31:0] map,
                                             input logic [`SSG_MODE_W-1:0] m);
    logic [7:0] b;
    b = map[m*8 +: 8];
    return b[NF-1:0];
  endfunction : funcs_of

  assign wr = psel & penable & pwrite;
  assign pready = 1'b1;
  assign mapped = (paddr <= `SSG_OFF_INT_MASK) && (paddr[1:0] == 2'h0);
  assign pslverr = psel & penable & ~mapped;
  assign mode_funcs = funcs_of(funcmap, mode_sel);
  // Mode change, retest and erase requests decoded from register writes.
  assign mode_chg = wr && paddr == `SSG_OFF_MODE
                    && pwdata[`SSG_MODE_W-1:0] != mode_sel;
  assign phys_chg = physcls[pwdata[`SSG_MODE_W-1:0]] != physcls[mode_sel];
  assign retest = wr && paddr == `SSG_OFF_CTRL && pwdata[`SSG_CTRL_RETEST];
  assign zero_req = wr && paddr == `SSG_OFF_CTRL && pwdata[`SSG_CTRL_ZEROIZE];

  // Control registers written by software.
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl <= 5'h00;
      mode_sel <= '0;
      funcmap <= `SSG_FUNCMAP_RST;
      physcls <= `SSG_PHYSCLS_RST;
      int_mask <= '0;
    end
    else if (wr)
    begin
      case (paddr)
        `SSG_OFF_CTRL: ctrl <= {2'h0, pwdata[2:0]};
        `SSG_OFF_MODE: mode_sel <= pwdata[`SSG_MODE_W-1:0];
        `SSG_OFF_FUNCMAP: funcmap <= pwdata;
        `SSG_OFF_PHYSCLS: physcls <= pwdata[`SSG_NMODE-1:0];
        `SSG_OFF_INT_MASK: int_mask <= pwdata[`SSG_INT_W-1:0];
        default: ctrl <= ctrl;
      endcase
    end
  end

  // Two arm bits, each in its own register; erased with the secrets.
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      arm_a <= 1'b0;
      arm_b <= 1'b0;
    end
    else if (state == ssg_pkg::SSG_ZERO || state == ssg_pkg::SSG_ERR)
    begin
      arm_a <= 1'b0;
      arm_b <= 1'b0;
    end
    else if (wr && paddr == `SSG_OFF_ARM_A)
    begin
      arm_a <= pwdata[0];
    end
    else if (wr && paddr == `SSG_OFF_ARM_B)
    begin
      arm_b <= pwdata[0];
    end
  end

  // Read mux; status is only ever visible here and on the indicator pins.
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata <= 32'h00000000;
    end
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        `SSG_OFF_CTRL: prdata <= {27'h0, ctrl};
        `SSG_OFF_MODE: prdata <= {30'h0, mode_sel};
        `SSG_OFF_FUNCMAP: prdata <= funcmap;
        `SSG_OFF_PHYSCLS: prdata <= {28'h0, physcls};
        `SSG_OFF_ARM_A: prdata <= {31'h0, arm_a};
        `SSG_OFF_ARM_B: prdata <= {31'h0, arm_b};
        `SSG_OFF_STATUS: prdata <= {22'h0, mode_sel, 1'b0, approved_mode_o, sw_ok,
                                    state == ssg_pkg::SSG_ZERO,
                                    state == ssg_pkg::SSG_START
                                    || state == ssg_pkg::SSG_WAIT,
                                    error_o, degraded_o,
                                    state == ssg_pkg::SSG_OPER};
        `SSG_OFF_FAILED: prdata <= {{(32-NF){1'b0}}, failed};
        `SSG_OFF_INT_STAT: prdata <= {28'h0, int_stat};
        `SSG_OFF_INT_MASK: prdata <= {28'h0, int_mask};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Security state machine
  // ----------------------------------------------------------------
  // Priority: fault, then erase request, then mode change, then retest.
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ssg_pkg::SSG_START;
      zero_to_err <= 1'b0;
    end
    else if (fault_sync && state != ssg_pkg::SSG_ZERO && state != ssg_pkg::SSG_ERR)
    begin
      state <= ssg_pkg::SSG_ZERO;
      zero_to_err <= 1'b1;
    end
    else
    begin
      case (state)
        ssg_pkg::SSG_START: state <= ssg_pkg::SSG_WAIT;
        ssg_pkg::SSG_WAIT:
        begin
          if (selftest_done_i)
          begin
            if (!selftest_integ_fail_i && (selftest_fail_i & mode_funcs) == '0)
              state <= ssg_pkg::SSG_OPER;
            else if (!selftest_integ_fail_i && (mode_funcs & ~selftest_fail_i) != '0)
              state <= ssg_pkg::SSG_DEGR;
            else
              state <= ssg_pkg::SSG_ERR;
          end
        end
        ssg_pkg::SSG_OPER, ssg_pkg::SSG_DEGR, ssg_pkg::SSG_ERR:
        begin
          if (zero_req)
          begin
            state <= ssg_pkg::SSG_ZERO;
            zero_to_err <= 1'b0;
          end
          else if (mode_chg && phys_chg)
          begin
            state <= ssg_pkg::SSG_ZERO;
            zero_to_err <= 1'b0;
          end
          else if (mode_chg || retest)
          begin
            state <= ssg_pkg::SSG_START;
          end
        end
        ssg_pkg::SSG_ZERO:
        begin
          if (zeroize_done_i)
            state <= zero_to_err ? ssg_pkg::SSG_ERR : ssg_pkg::SSG_START;
        end
        default: state <= ssg_pkg::SSG_ERR;
      endcase
    end
  end

  // Self-test outcome: integrity flag and set of failed functions.
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sw_ok <= 1'b0;
      failed <= '0;
    end
    else if (state == ssg_pkg::SSG_WAIT && selftest_done_i)
    begin
      sw_ok <= ~selftest_integ_fail_i;
      failed <= selftest_fail_i & mode_funcs;
    end
  end

  // Start pulse and function list for the self-test engine.
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      selftest_req_o <= 1'b0;
      selftest_funcs_o <= '0;
    end
    else
    begin
      selftest_req_o <= state == ssg_pkg::SSG_START;
      selftest_funcs_o <= mode_funcs;
    end
  end

  // Status indicators and function enables.
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      zeroize_req_o <= 1'b0;
      func_enable_o <= '0;
      approved_mode_o <= 1'b0;
      degraded_o <= 1'b0;
      error_o <= 1'b0;
    end
    else
    begin
      zeroize_req_o <= state == ssg_pkg::SSG_ZERO;
      func_enable_o <= (state == ssg_pkg::SSG_OPER || state == ssg_pkg::SSG_DEGR)
                       ? mode_funcs & ~failed : '0;
      approved_mode_o <= state == ssg_pkg::SSG_OPER
                         || state == ssg_pkg::SSG_DEGR;
      degraded_o <= state == ssg_pkg::SSG_DEGR;
      error_o <= state == ssg_pkg::SSG_ERR;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign ev[`SSG_INT_PASS] = state == ssg_pkg::SSG_WAIT && selftest_done_i
                             && !selftest_integ_fail_i
                             && (selftest_fail_i & mode_funcs) == '0;
  assign ev[`SSG_INT_FAIL] = state == ssg_pkg::SSG_WAIT && selftest_done_i
                             && !ev[`SSG_INT_PASS];
  assign ev[`SSG_INT_FAULT] = fault_sync && state != ssg_pkg::SSG_ZERO
                              && state != ssg_pkg::SSG_ERR;
  assign ev[`SSG_INT_MODE] = mode_chg;

  // Sticky status; a new event wins over a write-one clear.
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
      int_stat <= '0;
    else if (wr && paddr == `SSG_OFF_INT_STAT)
      int_stat <= (int_stat & ~pwdata[`SSG_INT_W-1:0]) | ev;
    else
      int_stat <= int_stat | ev;
  end

  assign irq_o = |(int_stat & int_mask);

  // ----------------------------------------------------------------
  // Output gate
  // ----------------------------------------------------------------
  ssg_gate_if gif ();

  assign gif.data_block = ~sw_ok
                          | (state != ssg_pkg::SSG_OPER && state != ssg_pkg::SSG_DEGR)
                          | ctrl[`SSG_CTRL_KEYGEN] | ctrl[`SSG_CTRL_MANUAL]
                          | ctrl[`SSG_CTRL_SWLOAD];
  assign gif.secret_open = arm_a & arm_b & ~gif.data_block;

  ssg_output_gate #(
    .NCH(NCH),
    .DW(DW)
  ) u_gate (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .gate(gif.gate),
    .ch_valid_i(ch_valid_i),
    .ch_data_i(ch_data_i),
    .ch_valid_o(ch_valid_o),
    .ch_data_o(ch_data_o),
    .secret_valid_i(critical_secret_valid_i),
    .secret_data_i(critical_secret_i),
    .secret_valid_o(critical_secret_valid_o),
    .secret_data_o(critical_secret_o)
  );

endmodule : ssg_secure_gate

// ===== ssg_secure_gate_monitor.sv
// Concurrent checker of the secure output gate ports.
`timescale 1ns/10ps
module ssg_secure_gate_monitor #(
  parameter int NCH = 2,
  parameter int DW = 32,
  parameter int NF = 8
) (
  input wire logic mclk_i, // Clock.
  input wire logic reset_n_i, // Reset, active low.
  input wire logic [NCH-1:0] ch_valid_o, // Gated valid.
  input wire logic critical_secret_valid_i, // Secret valid in.
  input wire logic [DW-1:0] critical_secret_i, // Secret in.
  input wire logic critical_secret_valid_o, // Secret valid out.
  input wire logic [DW-1:0] critical_secret_o, // Secret out.
  input wire logic selftest_req_o, // Test start.
  input wire logic selftest_done_i, // Test done.
  input wire logic selftest_integ_fail_i, // Integrity failed.
  input wire logic [NF-1:0] selftest_fail_i, // Failed functions.
  input wire logic zeroize_req_o, // Erase request.
  input wire logic zeroize_done_i, // Erase done.
  input wire logic sec_fault_i, // Fault pin.
  input wire logic error_o, // Error flag.
  input wire logic degraded_o, // Degraded flag.
  input wire logic approved_mode_o // Approved flag.
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!reset_n_i);
  // A clean self-test result, a newly raised fault and a shut output.
  sequence s_shut;
    ch_valid_o == '0 && !critical_secret_valid_o;
  endsequence
  sequence s_pass;
    selftest_done_i && !selftest_integ_fail_i && selftest_fail_i == '0;
  endsequence
  sequence s_fault;
    $rose(sec_fault_i);
  endsequence
  req_pulse_a: assert property (selftest_req_o |=> !selftest_req_o)
    else $error("test request wider than one cycle");
  test_block_a: assert property (selftest_req_o |-> ##2 s_shut)
    else $error("output open during self-test");
  err_block_a: assert property (error_o && $past(error_o) && $past(error_o, 2) |-> s_shut)
    else $error("output open in error state");
  zero_block_a: assert property (zeroize_req_o [*2] |-> s_shut)
    else $error("output open during erasure");
  zero_hold_a: assert property ($fell(zeroize_req_o) |->
    $past(zeroize_done_i) || $past(zeroize_done_i, 2))
    else $error("erase request dropped early");
  fault_resp_a: assert property (s_fault |-> ##[1:8] (zeroize_req_o || error_o))
    else $error("fault not answered by erasure");
  deg_cause_a: assert property ($rose(degraded_o) |->
    $past(selftest_done_i, 2) && $past(selftest_fail_i, 2) != '0)
    else $error("degraded without failed test");
  appr_ind_a: assert property (s_pass |-> ##2 approved_mode_o)
    else $error("approved flag missing after pass");
  secret_src_a: assert property (critical_secret_valid_o |->
    $past(critical_secret_valid_i) && critical_secret_o == $past(critical_secret_i))
    else $error("secret output not from secret port");
endmodule : ssg_secure_gate_monitor

bind ssg_secure_gate ssg_secure_gate_monitor #(.NCH(NCH), .DW(DW), .NF(NF)) u_mon (
  .mclk_i, .reset_n_i, .ch_valid_o, .critical_secret_valid_i, .critical_secret_i,
  .critical_secret_valid_o, .critical_secret_o, .selftest_req_o, .selftest_done_i,
  .selftest_integ_fail_i, .selftest_fail_i, .zeroize_req_o, .zeroize_done_i,
  .sec_fault_i, .error_o, .degraded_o, .approved_mode_o
);

// ===== ssg_partner.sv
// Model of the self-test and erasure engine beside the secure output gate.
`timescale 1ns/10ps
module ssg_partner #(
  parameter int NF = 8
) (
  input wire logic mclk_i, // Clock.
  input wire logic rst_n_i, // Reset, active low.
  input wire logic test_req_i, // Test start pulse.
  input wire logic zero_req_i, // Erase request level.
  input wire logic [NF-1:0] fail_set_i, // Functions that will fail.
  input wire logic integ_set_i, // Integrity test will fail.
  output logic done_o, // Test done pulse.
  output logic integ_fail_o, // Integrity result.
  output logic [NF-1:0] fail_o, // Failed functions.
  output logic zero_done_o // Erase done pulse.
);
  int tcnt, zcnt;
  logic zseen;
  logic [NF-1:0] junk;
  // Answers a test after four cycles and an erasure after five; results toggle when not valid.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tcnt <= 0;
      zcnt <= 0;
      zseen <= 1'b0;
      junk <= '0;
    end
    else
    begin
      junk <= ~junk;
      zseen <= zero_req_i;
      tcnt <= test_req_i ? 4 : (tcnt > 0 ? tcnt - 1 : 0);
      zcnt <= (zero_req_i && !zseen) ? 5 : (zcnt > 0 ? zcnt - 1 : 0);
    end
  end
  // Results are only meaningful during the done pulse.
  assign done_o = (tcnt == 1);
  assign zero_done_o = (zcnt == 1);
  assign fail_o = done_o ? fail_set_i : junk;
  assign integ_fail_o = done_o ? integ_set_i : junk[0];
endmodule : ssg_partner

// ===== ssg_secure_gate_test.sv
// Self-checking testbench of the secure output gate.
`timescale 1ns/10ps
`include "ssg_defines.svh"
module ssg_secure_gate_test;
  localparam int NCH = 2, DW = 32, NF = 8;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq_o, approved_mode_o, degraded_o, error_o;
  logic sec_fault_i = 1'b0;
  logic integ_set = 1'b0;
  logic selftest_req_o, selftest_done_i, selftest_integ_fail_i, zeroize_req_o, zeroize_done_i;
  logic [NF-1:0] fail_set = '0;
  logic [NF-1:0] selftest_funcs_o, selftest_fail_i, func_enable_o;
  logic [NCH-1:0] ch_valid_i = '0;
  logic [NCH-1:0] ch_valid_o, prev_v;
  logic [NCH*DW-1:0] ch_data_i = '0, ch_data_o;
  logic critical_secret_valid_i = 1'b0;
  logic critical_secret_valid_o, prev_sv;
  logic [DW-1:0] critical_secret_i = '0;
  logic [DW-1:0] critical_secret_o, prev_s, prev_d;
  logic [31:0] rnd = 32'h00000029;
  int n_errors = 0, checks = 0, open_exp = 0, sec_exp = 0, cyc = 0;

  ssg_secure_gate #(.NCH(NCH), .DW(DW), .NF(NF)) dut (
    .mclk_i, .reset_n_i, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .sec_fault_i, .selftest_req_o, .selftest_funcs_o, .selftest_done_i,
    .selftest_integ_fail_i, .selftest_fail_i, .zeroize_req_o, .zeroize_done_i,
    .func_enable_o, .approved_mode_o, .degraded_o, .error_o, .irq_o, .ch_valid_i,
    .ch_data_i, .ch_valid_o, .ch_data_o, .critical_secret_valid_i, .critical_secret_i,
    .critical_secret_valid_o, .critical_secret_o
  );
  ssg_partner #(.NF(NF)) u_partner (
    .mclk_i(mclk_i), .rst_n_i(reset_n_i), .test_req_i(selftest_req_o),
    .zero_req_i(zeroize_req_o), .fail_set_i(fail_set), .integ_set_i(integ_set),
    .done_o(selftest_done_i), .integ_fail_o(selftest_integ_fail_i),
    .fail_o(selftest_fail_i), .zero_done_o(zeroize_done_i)
  );

  // ------------------------------------------------------------
  // Clock, stimulus and reference model
  // ------------------------------------------------------------
  always #2.5 mclk_i = ~mclk_i;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop;
    if (n_errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop
  // Random traffic every cycle, and the cycle ceiling that cuts a hang short.
  always @(posedge mclk_i)
  begin
    rnd <= xs(rnd);
    ch_valid_i <= rnd[NCH-1:0];
    ch_data_i <= {rnd, ~rnd};
    critical_secret_valid_i <= rnd[4];
    critical_secret_i <= rnd ^ 32'hA5A5A5A5;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      report_and_stop;
    end
  end
  // Expected gate outputs: last cycle's inputs when open, zero when blocked.
  always @(negedge mclk_i)
  begin
    if (open_exp >= 0)
      chk("ch_valid_o", ch_valid_o, open_exp > 0 ? prev_v : 2'h0);
    if (open_exp >= 0)
      chk("ch_data_o", ch_data_o[31:0], open_exp > 0 ? prev_d : 32'h0);
    if (sec_exp >= 0)
      chk("secret_valid", critical_secret_valid_o, sec_exp > 0 ? prev_sv : 1'b0);
    if (sec_exp > 0 && prev_sv)
      chk("secret_data", critical_secret_o, prev_s);
    prev_v = ch_valid_i;
    prev_d = ch_data_i[31:0];
    prev_sv = critical_secret_valid_i;
    prev_s = critical_secret_i;
  end

  // ------------------------------------------------------------
  // Bus and wait tasks
  // ------------------------------------------------------------
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
    @(posedge mclk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? d : 32'h0;
    @(posedge mclk_i);
    penable <= 1'b1;
    do
      @(posedge mclk_i);
    while (pready !== 1'b1);
    if (!w)
      chk("prdata", prdata, d);
    chk("pslverr", pslverr, e);
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge mclk_i);
  endtask : bus
  task automatic wait_hi(input int w, input logic lvl);
    int i;
    logic s;
    for (i = 0; i < 300; i++)
    begin
      @(negedge mclk_i);
      case (w)
        0: s = approved_mode_o;
        1: s = degraded_o;
        2: s = error_o;
        3: s = zeroize_req_o;
        4: s = selftest_req_o;
        default: s = selftest_done_i;
      endcase
      if (s === lvl)
        break;
    end
    chk("wait", i < 300, 1'b1);
  endtask : wait_hi
  task automatic hold;
    open_exp = -1;
    sec_exp = -1;
  endtask : hold
  task automatic settle(input int o, input int s);
    repeat (6) @(negedge mclk_i);
    open_exp = o;
    sec_exp = s;
  endtask : settle
  task automatic retest(input logic [NF-1:0] f, input logic g);
    fail_set = f;
    integ_set = g;
    hold;
    bus(1'b1, `SSG_OFF_CTRL, 32'h8, 1'b0);
    wait_hi(4, 1'b1);
    repeat (8) @(negedge mclk_i);
  endtask : retest

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    wait_hi(5, 1'b1);
    hold;
    wait_hi(0, 1'b1);
    settle(1, 0);
    bus(1'b0, `SSG_OFF_STATUS, 32'h61, 1'b0);
    bus(1'b0, `SSG_OFF_FUNCMAP, 32'hFFFFFFFF, 1'b0);
    bus(1'b0, `SSG_OFF_PHYSCLS, 32'h0, 1'b0);
    bus(1'b0, `SSG_OFF_INT_STAT, 32'h1, 1'b0);
    bus(1'b0, 12'h028, 32'h0, 1'b1);
    bus(1'b1, 12'h002, 32'h1, 1'b1);
    for (int b = 0; b < 3; b++)
    begin
      hold;
      bus(1'b1, `SSG_OFF_CTRL, 32'h1 << b, 1'b0);
      settle(0, 0);
      hold;
      bus(1'b1, `SSG_OFF_CTRL, 32'h0, 1'b0);
      settle(1, 0);
    end
    bus(1'b1, `SSG_OFF_ARM_B, 32'h1, 1'b0);
    repeat (8) @(negedge mclk_i);
    hold;
    bus(1'b1, `SSG_OFF_ARM_A, 32'h1, 1'b0);
    settle(1, 1);
    hold;
    bus(1'b1, `SSG_OFF_CTRL, 32'h1, 1'b0);
    settle(0, 0);
    hold;
    bus(1'b1, `SSG_OFF_CTRL, 32'h0, 1'b0);
    settle(1, 1);
    bus(1'b1, `SSG_OFF_FUNCMAP, 32'hFFFFA5FF, 1'b0);
    bus(1'b1, `SSG_OFF_PHYSCLS, 32'h2, 1'b0);
    bus(1'b1, `SSG_OFF_INT_MASK, 32'hA, 1'b0);
    hold;
    bus(1'b1, `SSG_OFF_MODE, 32'h1, 1'b0);
    wait_hi(3, 1'b1);
    wait_hi(4, 1'b1);
    chk("funcs", selftest_funcs_o, 8'hA5);
    repeat (8) @(negedge mclk_i);
    settle(1, 0);
    chk("func_enable", func_enable_o, 8'hA5);
    chk("irq_mode", irq_o, 1'b1);
    bus(1'b1, `SSG_OFF_INT_STAT, 32'h8, 1'b0);
    chk("irq_clear", irq_o, 1'b0);
    bus(1'b0, `SSG_OFF_STATUS, 32'h161, 1'b0);
    retest(8'h01, 1'b0);
    chk("degraded", degraded_o, 1'b1);
    settle(1, 0);
    chk("func_iso", func_enable_o, 8'hA4);
    bus(1'b0, `SSG_OFF_FAILED, 32'h1, 1'b0);
    retest(8'h01, 1'b0);
    settle(1, 0);
    chk("still_degraded", degraded_o, 1'b1);
    chk("irq_fail", irq_o, 1'b1);
    bus(1'b1, `SSG_OFF_INT_STAT, 32'h2, 1'b0);
    chk("irq_fail_clr", irq_o, 1'b0);
    retest(8'h00, 1'b0);
    settle(1, 0);
    chk("left_degraded", degraded_o, 1'b0);
    chk("func_back", func_enable_o, 8'hA5);
    for (int k = 0; k < 2; k++)
    begin
      retest(k ? 8'h00 : 8'hA5, k == 1);
      settle(0, 0);
      chk("error", error_o, 1'b1);
      chk("func_off", func_enable_o, 8'h00);
      retest(8'h00, 1'b0);
      settle(1, 0);
      chk("error_left", error_o, 1'b0);
    end
    hold;
    @(posedge mclk_i);
    sec_fault_i <= 1'b1;
    wait_hi(3, 1'b1);
    wait_hi(2, 1'b1);
    settle(0, 0);
    @(posedge mclk_i);
    sec_fault_i <= 1'b0;
    retest(8'h00, 1'b0);
    settle(1, 0);
    chk("fault_left", error_o, 1'b0);
    repeat (10) @(negedge mclk_i);
    report_and_stop;
  end
endmodule : ssg_secure_gate_test
